/* src/dac_serial_and_async_control.sv */
// Serial slave port, load/clear pin handling and alarm output of the DAC
//
// Overview of operation
// - Sample data input into shift register on each serial clock rise while selected.
// - Select low enables the port; traffic is ignored while select is high.
// - Serial data output is high impedance whenever select is high.
// - Serial data output changes only at select fall and on serial clock falling edges.
// - Serial data output presents the shifted-out shift register contents.
// - Load pin low copies input register to DAC register immediately.
// - Alarm pulled low on open current output, shorted voltage output, or clear low.
// - Enabled clear forces code to clear register value or zero output code.
// - Clear register is written only over the serial port.
// - Clear pin changes the code only while the clear enable control bit is set; the alarm follows it regardless.
// - Select falling starts 24-bit frame: command byte then 16 data bits, MSB first.
// - Shift register keeps the 24 latest bits with no frame length check.
// - Select rising moves shift register into register picked by command.
// - Reset clears the control, input, DAC, clear and shift registers, returns the frame state to idle and keeps both outputs disabled.
`timescale 1ns/1ps
module dac_serial_and_async_control #(
  parameter int DATA_W = dac_ctrl_pkg::DATA_BITS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic din,
  output logic doutO,
  output logic doutOeN,
  input wire logic loadOutputN,
  input wire logic clearInputN,
  input wire logic currentOpen,
  input wire logic voltageShort,
  output logic alarmO,
  output logic alarmOeN,
  output logic [DATA_W-1:0] dacCode,
  output logic voltageOutputEnable,
  output logic bipolarMode,
  output logic clearActive
);

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  dac_ctrl_pkg::pins_t pinsRaw;
  dac_ctrl_pkg::pins_t pinsS;
  logic [dac_ctrl_pkg::PIN_COUNT-1:0] pinsSyncVec;

  assign pinsRaw.openCircuit = currentOpen;
  assign pinsRaw.shortCircuit = voltageShort;
  assign pinsRaw.clearInputN = clearInputN;
  assign pinsRaw.loadOutputN = loadOutputN;
  assign pinsRaw.din = din;
  assign pinsRaw.csN = csN;
  assign pinsRaw.sclk = sclk;

  // The serial clock is sampled, not used as a clock: it must stay well
  // below a quarter of clk so every level is seen by both stages.
  pin_sync #(
    .WIDTH(dac_ctrl_pkg::PIN_COUNT),
    .RESET_VAL(dac_ctrl_pkg::PIN_IDLE)
  ) u_pin_sync (
    .clk(clk),
    .srst(srst),
    .async(pinsRaw),
    .synced(pinsSyncVec)
  );

  assign pinsS = dac_ctrl_pkg::pins_t'(pinsSyncVec);

  logic sclkPrev_q;
  logic csNPrev_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sclkPrev_q <= 1'b0;
      csNPrev_q <= 1'b1;
    end
    else
    begin
      sclkPrev_q <= pinsS.sclk;
      csNPrev_q <= pinsS.csN;
    end
  end

  wire sclkRise = pinsS.sclk & ~sclkPrev_q;
  wire sclkFall = ~pinsS.sclk & sclkPrev_q;
  wire csFall = ~pinsS.csN & csNPrev_q;
  wire csRise = pinsS.csN & ~csNPrev_q;
  wire selected = ~pinsS.csN;

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  dac_ctrl_pkg::frame_state_t state_q;
  dac_ctrl_pkg::frame_state_t state_d;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      dac_ctrl_pkg::ST_IDLE:
      begin
        if (csFall)
          state_d = dac_ctrl_pkg::ST_FRAME;
      end
      dac_ctrl_pkg::ST_FRAME:
      begin
        if (csRise)
          state_d = dac_ctrl_pkg::ST_IDLE;
      end
      default:
        state_d = dac_ctrl_pkg::ST_IDLE;
    endcase
  end

  wire commit = csRise && (state_q == dac_ctrl_pkg::ST_FRAME);

  // ----------------------------------------------------------------
  // Shift register and command decode
  // ----------------------------------------------------------------
  logic [dac_ctrl_pkg::FRAME_BITS-1:0] shift_q;
  logic [dac_ctrl_pkg::FRAME_BITS-1:0] shift_d;
  dac_ctrl_pkg::frame_t frame;
  logic [dac_ctrl_pkg::OPCODE_BITS-1:0] opcode;

  assign frame = dac_ctrl_pkg::frame_t'(shift_q);
  assign opcode = frame.cmd[dac_ctrl_pkg::OPCODE_BITS-1:0];

  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] input_q;
  logic [DATA_W-1:0] dac_q;
  logic [DATA_W-1:0] clearReg_q;

  wire opWrCtrl = commit && (opcode == dac_ctrl_pkg::CMD_WR_CTRL);
  wire opRdCtrl = commit && (opcode == dac_ctrl_pkg::CMD_RD_CTRL);
  wire opLdInput = commit && (opcode == dac_ctrl_pkg::CMD_LD_INPUT);
  wire opLdBoth = commit && (opcode == dac_ctrl_pkg::CMD_LD_BOTH);
  wire opLdDac = commit && (opcode == dac_ctrl_pkg::CMD_LD_DAC);
  wire opWrClear = commit && (opcode == dac_ctrl_pkg::CMD_WR_CLEAR);
  wire opRdInput = commit && (opcode == dac_ctrl_pkg::CMD_RD_INPUT);
  wire opRdDac = commit && (opcode == dac_ctrl_pkg::CMD_RD_DAC);
  wire opRead = opRdCtrl | opRdInput | opRdDac;

  wire [DATA_W-1:0] readData = opRdCtrl ? ctrl_q :
                               opRdInput ? input_q : dac_q;

  // Unknown opcodes and no-op leave every register untouched; the frame
  // stays in the shift register, so a chain passes it on unchanged.
  always_comb
  begin
    shift_d = shift_q;
    if (sclkRise && selected)
      shift_d = {shift_q[dac_ctrl_pkg::FRAME_BITS-2:0], pinsS.din};
    else if (opRead)
      shift_d = {frame.cmd, readData};
  end

  // ----------------------------------------------------------------
  // Internal registers
  // ----------------------------------------------------------------
  wire [DATA_W-1:0] ctrl_d = opWrCtrl ? frame.data : ctrl_q;
  wire [DATA_W-1:0] clearReg_d = opWrClear ? frame.data : clearReg_q;
  wire [DATA_W-1:0] input_d = (opLdInput | opLdBoth) ? frame.data : input_q;

  // Load pin low keeps the DAC register tracking the input register;
  // a serial load in the same cycle already sits in input_d.
  wire loadActive = ~pinsS.loadOutputN;
  wire [DATA_W-1:0] dac_d = opLdBoth ? frame.data :
                            (opLdDac | loadActive) ? input_d : dac_q;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= dac_ctrl_pkg::ST_IDLE;
      shift_q <= dac_ctrl_pkg::SHIFT_RESET;
    end
    else
    begin
      state_q <= state_d;
      shift_q <= shift_d;
    end
  end

  // One process per register keeps each commit path easy to follow
  always_ff @(posedge clk)
  begin
    if (srst)
      ctrl_q <= dac_ctrl_pkg::REG_RESET;
    else
      ctrl_q <= ctrl_d;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      input_q <= dac_ctrl_pkg::REG_RESET;
    else
      input_q <= input_d;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      dac_q <= dac_ctrl_pkg::REG_RESET;
    else
      dac_q <= dac_d;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      clearReg_q <= dac_ctrl_pkg::REG_RESET;
    else
      clearReg_q <= clearReg_d;
  end

  // ----------------------------------------------------------------
  // Serial data output
  // ----------------------------------------------------------------
  logic dout_q;
  logic doutOeN_q;

  // The MSB is put out at select fall and after each falling serial clock,
  // so the master samples a stable bit on the rising edge.
  wire doutLoad = csFall | (sclkFall & selected);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dout_q <= 1'b0;
      doutOeN_q <= 1'b1;
    end
    else
    begin
      if (doutLoad)
        dout_q <= shift_q[dac_ctrl_pkg::FRAME_BITS-1];
      doutOeN_q <= ~selected;
    end
  end

  assign doutO = dout_q;
  assign doutOeN = doutOeN_q;

  // ----------------------------------------------------------------
  // Clear handling and output code
  // ----------------------------------------------------------------
  wire clearEnable = ctrl_q[dac_ctrl_pkg::CTRL_CLEAR_INPUT_ENABLE_BIT];
  wire clearToZero = ctrl_q[dac_ctrl_pkg::CTRL_CLRZERO_BIT];
  wire bipolar = ctrl_q[dac_ctrl_pkg::CTRL_BIPOLAR_BIT];
  wire clearing = ~pinsS.clearInputN & clearEnable;

  // Zero output in bipolar voltage mode is mid-scale; in current mode code
  // zero gives 0 mA or 4 mA depending on the range chosen elsewhere.
  wire [DATA_W-1:0] zeroCode = bipolar ? dac_ctrl_pkg::ZERO_CODE_BIP :
                                         dac_ctrl_pkg::ZERO_CODE_UNI;
  wire [DATA_W-1:0] clearCode = clearToZero ? zeroCode : clearReg_q;
  wire [DATA_W-1:0] code_d = clearing ? clearCode : dac_q;

  // ----------------------------------------------------------------
  // Alarm output, open drain
  // ----------------------------------------------------------------
  wire alarmCond = pinsS.openCircuit | pinsS.shortCircuit | ~pinsS.clearInputN;

  logic [DATA_W-1:0] code_q;
  logic alarmOeN_q;
  logic clearActive_q;

  always_ff @(posedge clk)
  begin
    if (srst)
      code_q <= dac_ctrl_pkg::REG_RESET;
    else
      code_q <= code_d;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      alarmOeN_q <= 1'b1;
    else
      alarmOeN_q <= ~alarmCond;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      clearActive_q <= 1'b0;
    else
      clearActive_q <= clearing;
  end

  assign dacCode = code_q;
  assign alarmO = 1'b0;
  assign alarmOeN = alarmOeN_q;
  assign clearActive = clearActive_q;
  assign voltageOutputEnable = ctrl_q[dac_ctrl_pkg::CTRL_OUTEN_BIT];
  assign bipolarMode = bipolar;

endmodule // dac_serial_and_async_control

/* src/dac_ctrl_pkg.sv */
// Constants and types shared by the DAC serial and asynchronous control logic
package dac_ctrl_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int CMD_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam int OPCODE_BITS = 4;

  typedef struct packed {
    logic [CMD_BITS-1:0] cmd;
    logic [DATA_BITS-1:0] data;
  } frame_t;

  // ----------------------------------------------------------------
  // Command opcodes (low nibble of the command byte)
  // ----------------------------------------------------------------
  localparam logic [OPCODE_BITS-1:0] CMD_NOP = 4'h0;
  localparam logic [OPCODE_BITS-1:0] CMD_WR_CTRL = 4'h1;
  localparam logic [OPCODE_BITS-1:0] CMD_RD_CTRL = 4'h2;
  localparam logic [OPCODE_BITS-1:0] CMD_LD_INPUT = 4'h3;
  localparam logic [OPCODE_BITS-1:0] CMD_LD_BOTH = 4'h4;
  localparam logic [OPCODE_BITS-1:0] CMD_LD_DAC = 4'h5;
  localparam logic [OPCODE_BITS-1:0] CMD_WR_CLEAR = 4'h6;
  localparam logic [OPCODE_BITS-1:0] CMD_RD_INPUT = 4'h7;
  localparam logic [OPCODE_BITS-1:0] CMD_RD_DAC = 4'h8;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_CLEAR_INPUT_ENABLE_BIT = 0;
  localparam int CTRL_CLRZERO_BIT = 1;
  localparam int CTRL_BIPOLAR_BIT = 2;
  localparam int CTRL_OUTEN_BIT = 3;
  localparam logic [DATA_BITS-1:0] REG_RESET = 16'h0000;
  localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 24'h000000;
  localparam logic [DATA_BITS-1:0] ZERO_CODE_UNI = 16'h0000;
  localparam logic [DATA_BITS-1:0] ZERO_CODE_BIP = 16'h8000;

  // ----------------------------------------------------------------
  // Synchronised pin vector
  // ----------------------------------------------------------------
  typedef struct packed {
    logic openCircuit;
    logic shortCircuit;
    logic clearInputN;
    logic loadOutputN;
    logic din;
    logic csN;
    logic sclk;
  } pins_t;

  localparam int PIN_COUNT = 7;
  // Idle levels: selects and strobes released high, status quiet
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 7'h1A;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FRAME = 2'b10
  } frame_state_t;

endpackage

/* src/pin_sync.sv */
// Two-stage synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  // ----------------------------------------------------------------
  // First stage feeds only the second stage
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stage1_q <= RESET_VAL;
      stage2_q <= RESET_VAL;
    end
    else
    begin
      stage1_q <= async;
      stage2_q <= stage1_q;
    end
  end

  assign synced = stage2_q;

endmodule // pin_sync

/* bench/dac_ctrl_monitor.sv */
// Assertion checker for the DAC serial and asynchronous control block
`timescale 1ns/1ps
module dac_ctrl_monitor #(
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic doutO,
  input wire logic doutOeN,
  input wire logic loadOutputN,
  input wire logic clearInputN,
  input wire logic currentOpen,
  input wire logic voltageShort,
  input wire logic alarmO,
  input wire logic alarmOeN,
  input wire logic [DATA_W-1:0] dacCode,
  input wire logic clearActive
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Pin counts allow for the two-flop synchroniser plus one register
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_dout_released: assert property (csN [*5] |-> doutOeN)
    else $error("dout driven while unselected");
  a_dout_driven: assert property (!csN [*5] |-> !doutOeN)
    else $error("dout not driven while selected");
  a_dout_on_fall: assert property ((!csN && sclk) [*3] |-> $stable(doutO))
    else $error("dout moved while serial clock high");
  a_alarm_set: assert property ((currentOpen || voltageShort || !clearInputN) [*5] |-> !alarmOeN)
    else $error("alarm not pulled low");
  a_alarm_free: assert property ((!currentOpen && !voltageShort && clearInputN) [*5] |-> alarmOeN)
    else $error("alarm held without cause");
  a_drain_only: assert property (alarmO == 1'b0)
    else $error("alarm pin drives high");
  a_clear_gated: assert property (clearInputN [*6] |-> !clearActive)
    else $error("clear active with pin high");
  a_code_quiet: assert property ((csN && loadOutputN && clearInputN) [*8] |-> $stable(dacCode))
    else $error("code changed with no cause");
  a_reset_quiet: assert property (disable iff (1'b0) srst |=> doutOeN && alarmOeN && dacCode == '0)
    else $error("outputs active after reset");
endmodule // dac_ctrl_monitor

bind dac_serial_and_async_control dac_ctrl_monitor #(.DATA_W(DATA_W)) u_mon (.clk, .srst, .sclk,
  .csN, .doutO, .doutOeN, .loadOutputN, .clearInputN, .currentOpen, .voltageShort, .alarmO,
  .alarmOeN, .dacCode, .clearActive);

/* bench/spi_master_model.sv */
// Serial bus master model driving frames into the DAC port
`timescale 1ns/1ps
module spi_master_model (
  input wire logic clk,
  input wire logic dout,
  output logic sclk,
  output logic csN,
  output logic din
);
  initial
  begin
    sclk = 1'b0;
    csN = 1'b1;
    din = 1'b0;
  end
  // Half of the 64 ns serial period
  task automatic half();
    repeat (8) @(posedge clk);
    #1;
  endtask
  // Serial clock stands low between frames
  task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
    half();
    csN = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      din = tx[i];
      half();
      sclk = 1'b1;
      rx[i] = dout;
      half();
      sclk = 1'b0;
    end
    half();
    csN = 1'b1;
    din = ~din;
    half();
  endtask
  // Clock pulses with select high; the port must not shift them in
  task automatic stray(input logic [7:0] bits);
    for (int i = 7; i >= 0; i--)
    begin
      din = bits[i];
      half();
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
  endtask
endmodule // spi_master_model

/* bench/tb.sv */
// Self-checking testbench for the DAC serial and asynchronous control block
`timescale 1ns/1ps
module tb;
  logic clk, srst, loadOutputN, clearInputN, currentOpen, voltageShort;
  logic doutO, doutOeN, alarmO, alarmOeN, voltageOutputEnable, bipolarMode, clearActive;
  logic doutLast, alarmLine, doutLine;
  wire sclk, csN, din;
  logic [15:0] dacCode, ctrlM, inM, dacM, clrM;
  logic [23:0] expShift;
  logic [31:0] rnd;
  int seed = 22;
  int failCount = 0;
  int checks = 0;
  logic [15:0] cv [4] = '{16'h0001, 16'h0003, 16'h0007, 16'h0000};

  dac_serial_and_async_control u_dac_serial_and_async_control (.clk(clk), .srst(srst),
    .sclk(sclk), .csN(csN), .din(din), .doutO(doutO), .doutOeN(doutOeN),
    .loadOutputN(loadOutputN), .clearInputN(clearInputN), .currentOpen(currentOpen),
    .voltageShort(voltageShort), .alarmO(alarmO), .alarmOeN(alarmOeN), .dacCode(dacCode),
    .voltageOutputEnable(voltageOutputEnable), .bipolarMode(bipolarMode),
    .clearActive(clearActive));
  spi_master_model u_spi_master_model (.clk(clk), .dout(doutLine), .sclk(sclk), .csN(csN),
    .din(din));

  // A released dout must not look held, so it shows the inverse of its last level
  always @(posedge clk) if (!doutOeN) doutLast <= doutO;
  assign doutLine = doutOeN ? ~doutLast : doutO;
  assign alarmLine = alarmOeN ? 1'b1 : alarmO;
  always #2 clk = ~clk;

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e)
    begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic printVerdict();
    $display("checks %0d failures %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [15:0] expCode();
    if (!clearInputN && ctrlM[dac_ctrl_pkg::CTRL_CLEAR_INPUT_ENABLE_BIT])
      return ctrlM[1] ? (ctrlM[2] ? dac_ctrl_pkg::ZERO_CODE_BIP : 16'h0000) : clrM;
    return dacM;
  endfunction
  // Always dual-supply here, so the alarm is always meaningful
  function automatic logic expAlarm();
    return !(currentOpen || voltageShort || !clearInputN);
  endfunction
  task automatic go(input logic [7:0] c, input logic [15:0] d);
    logic [23:0] r;
    u_spi_master_model.xfer({c, d}, r);
    chk("dout", expShift, r);
    expShift = {c, d};
    case (c[3:0])
      dac_ctrl_pkg::CMD_WR_CTRL: ctrlM = d;
      dac_ctrl_pkg::CMD_RD_CTRL: expShift[15:0] = ctrlM;
      dac_ctrl_pkg::CMD_LD_INPUT: inM = d;
      dac_ctrl_pkg::CMD_LD_BOTH:
      begin
        inM = d;
        dacM = d;
      end
      dac_ctrl_pkg::CMD_LD_DAC: dacM = inM;
      dac_ctrl_pkg::CMD_WR_CLEAR: clrM = d;
      dac_ctrl_pkg::CMD_RD_INPUT: expShift[15:0] = inM;
      dac_ctrl_pkg::CMD_RD_DAC: expShift[15:0] = dacM;
      default: ;
    endcase
    chk("dac code", expCode(), dacCode);
    chk("out enable", ctrlM[3], voltageOutputEnable);
    chk("bipolar", ctrlM[2], bipolarMode);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    loadOutputN = 1'b1;
    clearInputN = 1'b1;
    {currentOpen, voltageShort} = 2'b00;
    {ctrlM, inM, dacM, clrM, expShift} = '0;
    repeat (6) @(posedge clk);
    #1 srst = 1'b0;
    chk("reset code", 16'h0000, dacCode);
    chk("reset dout oe", 1'b1, doutOeN);
    chk("reset alarm", 1'b1, alarmLine);
    $display("test reset done");
    for (int k = 0; k < 24; k++)
    begin
      rnd = $random(seed);
      go({rnd[7:4], (k < 16) ? k[3:0] : rnd[3:0]}, rnd[23:8]);
    end
    $display("test commands done");
    rnd = $random(seed);
    go({4'h0, dac_ctrl_pkg::CMD_WR_CLEAR}, rnd[15:0]);
    for (int k = 0; k < 4; k++)
    begin
      go({4'h0, dac_ctrl_pkg::CMD_WR_CTRL}, cv[k]);
      clearInputN = 1'b0;
      tick(8);
      chk("cleared code", expCode(), dacCode);
      chk("clear active", ctrlM[0], clearActive);
      chk("alarm on clear", 1'b0, alarmLine);
      clearInputN = 1'b1;
      tick(8);
      chk("code after clear", dacM, dacCode);
      chk("alarm released", 1'b1, alarmLine);
    end
    $display("test clear done");
    rnd = $random(seed);
    go({4'h0, dac_ctrl_pkg::CMD_LD_INPUT}, rnd[15:0]);
    loadOutputN = 1'b0;
    dacM = inM;
    tick(8);
    chk("loaded code", dacM, dacCode);
    loadOutputN = 1'b1;
    tick(4);
    $display("test load done");
    for (int k = 1; k < 4; k++)
    begin
      {currentOpen, voltageShort} = k[1:0];
      tick(8);
      chk("fault alarm", expAlarm(), alarmLine);
      {currentOpen, voltageShort} = 2'b00;
      tick(8);
      chk("fault released", 1'b1, alarmLine);
    end
    $display("test alarm done");
    rnd = $random(seed);
    u_spi_master_model.stray(rnd[7:0]);
    go(8'h00, 16'h0000);
    $display("test stray clocks done");
    printVerdict();
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    failCount++;
    $display("test run timed out");
    printVerdict();
  end
endmodule // tb
